// file: src/antsup_defs.vh
// Constants for the active antenna supervisor.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef ANTSUP_DEFS_VH
`define ANTSUP_DEFS_VH

// Antenna state codes
`define ST_INIT       2'h0
`define ST_OK         2'h1
`define ST_SHORT      2'h2
`define ST_OPEN       2'h3

// Feature summary bit positions
`define FEAT_AC       0
`define FEAT_SD       1
`define FEAT_OD       2
`define FEAT_POWER_DOWN 3
`define FEAT_RECOVERY   4
`define FEAT_W        5

// Retry delay: time in microseconds, cycles derived at 50 MHz
`define CLK_MHZ       50
`define RETRY_US      1000
`define RETRY_CYC     (`RETRY_US * `CLK_MHZ)
// Retest window after power is restored, in cycles
`define RETEST_CYC    16'h0010
// Startup sequence sample delay, in cycles
`define START_CYC     8'h08

`endif

// file: src/antsup_sync.v
// Three-stage synchroniser for one pin input with agreement filter.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none

module antsup_sync #(
  parameter RESET_VAL = 1'b1
) (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_n_i,
  // Pin and filtered level
  input  wire pin_i,
  output reg  level_o
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q    <= RESET_VAL;
      s2_q    <= RESET_VAL;
      s3_q    <= RESET_VAL;
      level_o <= RESET_VAL;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change counts only once two stages agree
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end

endmodule

`default_nettype wire

// file: src/antenna_supervisor.v
// Active antenna supervisor: power-off pin, short and presence sensing,
// state tracking and report pulses.
// Assumes enable bits come from synchronous config logic on CLK_SYS_I;
// the sense pins are asynchronous and are synchronised here.
`timescale 1ns/1ns
`default_nettype none
`include "antsup_defs.vh"

module antenna_supervisor #(
  parameter RETRY_CYCLES = `RETRY_CYC
) (
  // Clock and reset
  input  wire       CLK_SYS_I,
  input  wire       RESETN_I,
  // Configuration bits
  input  wire       POWER_CONTROL_ENABLE_I,
  input  wire       FAULT_CHECK_ENABLE_I,
  input  wire       AUTO_RETRY_ENABLE_I,
  input  wire       PRESENCE_CHECK_ENABLE_I,
  // Antenna pins
  input  wire       ANTENNA_SHORT_N_I,
  input  wire       ANTENNA_PRESENT_SENSE_I,
  output reg        ANTENNA_POWER_OFF_O,
  // Reports
  output reg        SUPERVISOR_SUMMARY_REPORT_O,
  output reg  [4:0] SUMMARY_FEATURES_O,
  output reg        ANTENNA_STATE_REPORT_O,
  output reg  [1:0] REPORT_STATE_O,
  output reg  [1:0] ANTENNA_STATE_O,
  output reg        POWER_STATUS_ON_O
);

  localparam [1:0] SEQ_SUMMARY = 2'h0;
  localparam [1:0] SEQ_INIT    = 2'h1;
  localparam [1:0] SEQ_RUN     = 2'h2;
  localparam [1:0] SEQ_IDLE    = 2'h3;

  wire short_n_s;
  wire present_s;

  reg  [1:0]  seq_q;
  reg  [7:0]  start_cnt_q;
  reg  [31:0] retry_cnt_q;
  reg  [15:0] retest_cnt_q;
  reg         cut_q;
  reg         retesting_q;
  reg         latched_q;
  reg         fault_en_q;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  wire        short_now;
  wire        open_now;

  antsup_sync #(.RESET_VAL(1'b1)) u_sync_short (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RESETN_I),
    .pin_i   (ANTENNA_SHORT_N_I),
    .level_o (short_n_s)
  );

  antsup_sync #(.RESET_VAL(1'b1)) u_sync_present (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RESETN_I),
    .pin_i   (ANTENNA_PRESENT_SENSE_I),
    .level_o (present_s)
  );

  // short active low, only when enabled
  assign short_now = FAULT_CHECK_ENABLE_I && !short_n_s;
  // presence low means open; external drive assumed
  assign open_now  = PRESENCE_CHECK_ENABLE_I && !present_s;

  // latched short holds state until fault check or power control is disabled
  always @* begin
    state_d = state_q;
    if (latched_q) begin
      state_d = `ST_SHORT;
    end else if (cut_q) begin
      state_d = `ST_SHORT;
    end else if (short_now) begin
      state_d = `ST_SHORT;
    end else if (retesting_q && FAULT_CHECK_ENABLE_I) begin
      state_d = state_q;
    end else if (open_now) begin
      state_d = `ST_OPEN;
    end else begin
      state_d = `ST_OK;
    end
  end

  always @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      seq_q                       <= SEQ_SUMMARY;
      start_cnt_q                 <= 8'h00;
      retry_cnt_q                 <= 32'h00000000;
      retest_cnt_q                <= 16'h0000;
      cut_q                       <= 1'b0;
      retesting_q                 <= 1'b0;
      latched_q                   <= 1'b0;
      fault_en_q                  <= 1'b0;
      state_q                     <= `ST_INIT;
      ANTENNA_POWER_OFF_O         <= 1'b0;
      SUPERVISOR_SUMMARY_REPORT_O <= 1'b0;
      SUMMARY_FEATURES_O          <= 5'h00;
      ANTENNA_STATE_REPORT_O      <= 1'b0;
      REPORT_STATE_O              <= `ST_INIT;
      ANTENNA_STATE_O             <= `ST_INIT;
      POWER_STATUS_ON_O           <= 1'b1;
    end else begin
      SUPERVISOR_SUMMARY_REPORT_O <= 1'b0;
      ANTENNA_STATE_REPORT_O      <= 1'b0;
      fault_en_q                  <= FAULT_CHECK_ENABLE_I;
      case (seq_q)
        SEQ_SUMMARY: begin
          // Let synchronisers settle before the first judgement
          if (start_cnt_q == `START_CYC) begin
            if (POWER_CONTROL_ENABLE_I) begin
              SUPERVISOR_SUMMARY_REPORT_O       <= 1'b1;
              SUMMARY_FEATURES_O[`FEAT_AC]      <= 1'b1;
              SUMMARY_FEATURES_O[`FEAT_SD]      <= FAULT_CHECK_ENABLE_I;
              SUMMARY_FEATURES_O[`FEAT_OD]      <= PRESENCE_CHECK_ENABLE_I;
              SUMMARY_FEATURES_O[`FEAT_POWER_DOWN] <= AUTO_RETRY_ENABLE_I;
              SUMMARY_FEATURES_O[`FEAT_RECOVERY]   <= AUTO_RETRY_ENABLE_I;
              seq_q                             <= SEQ_INIT;
            end else begin
              seq_q <= SEQ_IDLE;
            end
          end else begin
            start_cnt_q <= start_cnt_q + 8'h01;
          end
        end
        SEQ_INIT: begin
          if (!POWER_CONTROL_ENABLE_I) begin
            seq_q <= SEQ_IDLE;
          end else begin
            // INIT report, then current state next cycle
            ANTENNA_STATE_REPORT_O <= 1'b1;
            REPORT_STATE_O         <= `ST_INIT;
            state_q                <= `ST_INIT;
            seq_q                  <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (!POWER_CONTROL_ENABLE_I) begin
            ANTENNA_POWER_OFF_O <= 1'b0;
            POWER_STATUS_ON_O   <= 1'b1;
            cut_q               <= 1'b0;
            retesting_q         <= 1'b0;
            latched_q           <= 1'b0;
            state_q             <= `ST_INIT;
            ANTENNA_STATE_O     <= `ST_INIT;
            seq_q               <= SEQ_IDLE;
          end else begin
            // disabling fault check clears a held short
            if (fault_en_q && !FAULT_CHECK_ENABLE_I) begin
              latched_q <= 1'b0;
            end else if (short_now && !AUTO_RETRY_ENABLE_I) begin
              latched_q <= 1'b1;
            end
            if (cut_q) begin
              // wait out the retry delay with power off
              // Withdrawn retry or fault check ends the cut at once
              if (!AUTO_RETRY_ENABLE_I || !FAULT_CHECK_ENABLE_I ||
                  retry_cnt_q >= RETRY_CYCLES - 1) begin
                cut_q               <= 1'b0;
                retesting_q         <= 1'b1;
                retest_cnt_q        <= 16'h0000;
                ANTENNA_POWER_OFF_O <= 1'b0;
                POWER_STATUS_ON_O   <= 1'b1;
              end else begin
                retry_cnt_q <= retry_cnt_q + 32'h00000001;
              end
            end else if (short_now && AUTO_RETRY_ENABLE_I && !latched_q) begin
              cut_q               <= 1'b1;
              retesting_q         <= 1'b0;
              retry_cnt_q         <= 32'h00000000;
              ANTENNA_POWER_OFF_O <= 1'b1;
              POWER_STATUS_ON_O   <= 1'b0;
            end else if (retesting_q) begin
              // retest window lets the sense path settle
              if (retest_cnt_q == `RETEST_CYC) begin
                retesting_q <= 1'b0;
              end else begin
                retest_cnt_q <= retest_cnt_q + 16'h0001;
              end
            end
            // report only on a real change
            // current state always on a port
            if (state_d != state_q) begin
              ANTENNA_STATE_REPORT_O <= 1'b1;
              REPORT_STATE_O         <= state_d;
            end
            state_q         <= state_d;
            ANTENNA_STATE_O <= state_d;
          end
        end
        default: begin
          // idle until power control enabled, then restart sequence
          ANTENNA_POWER_OFF_O <= 1'b0;
          POWER_STATUS_ON_O   <= 1'b1;
          if (POWER_CONTROL_ENABLE_I) begin
            start_cnt_q <= `START_CYC;
            seq_q       <= SEQ_SUMMARY;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// file: tb/antsup_chk.sv
// Port checker for the antenna supervisor.
// Assumes enables stay stable around reset release.
`timescale 1ns/1ns
`default_nettype none
`include "antsup_defs.vh"
module antsup_chk #(
  parameter int RETRY_CYCLES = 20
) (
  input wire logic       CLK_SYS_I,
  input wire logic       RESETN_I,
  input wire logic       POWER_CONTROL_ENABLE_I,
  input wire logic       FAULT_CHECK_ENABLE_I,
  input wire logic       AUTO_RETRY_ENABLE_I,
  input wire logic       PRESENCE_CHECK_ENABLE_I,
  input wire logic       ANTENNA_POWER_OFF_O,
  input wire logic       SUPERVISOR_SUMMARY_REPORT_O,
  input wire logic [4:0] SUMMARY_FEATURES_O,
  input wire logic       ANTENNA_STATE_REPORT_O,
  input wire logic [1:0] REPORT_STATE_O,
  input wire logic [1:0] ANTENNA_STATE_O
);
  localparam int RETRY_MAX = RETRY_CYCLES + 4;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  a_quiet_when_off: assert property (!POWER_CONTROL_ENABLE_I && !$past(POWER_CONTROL_ENABLE_I)
    |-> !ANTENNA_STATE_REPORT_O && !SUPERVISOR_SUMMARY_REPORT_O) else $error("report while off");
  a_power_kept_on: assert property (!AUTO_RETRY_ENABLE_I && !$past(AUTO_RETRY_ENABLE_I)
    |-> !ANTENNA_POWER_OFF_O) else $error("power cut without retry");
  a_summary_bits: assert property (SUPERVISOR_SUMMARY_REPORT_O |-> SUMMARY_FEATURES_O ==
    {AUTO_RETRY_ENABLE_I, AUTO_RETRY_ENABLE_I, PRESENCE_CHECK_ENABLE_I, FAULT_CHECK_ENABLE_I,
     POWER_CONTROL_ENABLE_I}) else $error("summary features wrong");
  a_summary_then_init: assert property (SUPERVISOR_SUMMARY_REPORT_O
    |=> ANTENNA_STATE_REPORT_O && REPORT_STATE_O == `ST_INIT) else $error("no init report");
  a_init_then_state: assert property (ANTENNA_STATE_REPORT_O && REPORT_STATE_O == `ST_INIT
    |=> ANTENNA_STATE_REPORT_O && REPORT_STATE_O != `ST_INIT) else $error("no state report");
  a_short_cuts_power: assert property (ANTENNA_STATE_REPORT_O && REPORT_STATE_O == `ST_SHORT
    && AUTO_RETRY_ENABLE_I |-> ##[0:2] ANTENNA_POWER_OFF_O) else $error("power not cut");
  a_retry_timeout: assert property ($rose(ANTENNA_POWER_OFF_O)
    |=> ANTENNA_POWER_OFF_O [*8] ##[1:RETRY_MAX] !ANTENNA_POWER_OFF_O) else $error("bad retry");
  a_fault_off_clears: assert property ($fell(FAULT_CHECK_ENABLE_I)
    |-> ##[1:8] ANTENNA_STATE_O != `ST_SHORT) else $error("short not cleared");
endmodule
bind antenna_supervisor antsup_chk #(.RETRY_CYCLES(RETRY_CYCLES)) u_antsup_chk (
  .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .POWER_CONTROL_ENABLE_I(POWER_CONTROL_ENABLE_I),
  .FAULT_CHECK_ENABLE_I(FAULT_CHECK_ENABLE_I), .AUTO_RETRY_ENABLE_I(AUTO_RETRY_ENABLE_I),
  .PRESENCE_CHECK_ENABLE_I(PRESENCE_CHECK_ENABLE_I), .ANTENNA_POWER_OFF_O(ANTENNA_POWER_OFF_O),
  .SUPERVISOR_SUMMARY_REPORT_O(SUPERVISOR_SUMMARY_REPORT_O),
  .SUMMARY_FEATURES_O(SUMMARY_FEATURES_O), .ANTENNA_STATE_REPORT_O(ANTENNA_STATE_REPORT_O),
  .REPORT_STATE_O(REPORT_STATE_O), .ANTENNA_STATE_O(ANTENNA_STATE_O));
`default_nettype wire

// file: tb/antenna_model.sv
// Bias circuit model with short and presence sensing.
// Assumes the bench commands faults; power pin from the supervisor.
`timescale 1ns/1ns
`default_nettype none
module antenna_model (
  input  wire logic power_off_i,
  input  wire logic short_i,
  input  wire logic absent_i,
  output wire logic short_n_o,
  output wire logic present_o
);
  assign short_n_o = !(short_i && !power_off_i);
  assign present_o = !power_off_i && !absent_i;
endmodule
`default_nettype wire

// file: tb/antenna_supervisor_tb.sv
// Self-checking bench for the antenna supervisor.
// Assumes the retry delay is shortened to 20 cycles.
`timescale 1ns/1ns
`default_nettype none
`include "antsup_defs.vh"
module antenna_supervisor_tb;
  logic            clk, rst_n, pce, fce, are, pre, shorted, absent;
  wire logic       short_n, present, poff, sum_p, st_p, pwr_on;
  wire logic [4:0] feat;
  wire logic [1:0] rep, st;
  integer          err_count, n_checks, seen, i;
  antenna_supervisor #(.RETRY_CYCLES(20)) u_antenna_supervisor (
    .CLK_SYS_I(clk), .RESETN_I(rst_n), .POWER_CONTROL_ENABLE_I(pce),
    .FAULT_CHECK_ENABLE_I(fce), .AUTO_RETRY_ENABLE_I(are), .PRESENCE_CHECK_ENABLE_I(pre),
    .ANTENNA_SHORT_N_I(short_n), .ANTENNA_PRESENT_SENSE_I(present),
    .ANTENNA_POWER_OFF_O(poff), .SUPERVISOR_SUMMARY_REPORT_O(sum_p), .SUMMARY_FEATURES_O(feat),
    .ANTENNA_STATE_REPORT_O(st_p), .REPORT_STATE_O(rep), .ANTENNA_STATE_O(st),
    .POWER_STATUS_ON_O(pwr_on));
  antenna_model u_antenna_model (.power_off_i(poff), .short_i(shorted), .absent_i(absent),
    .short_n_o(short_n), .present_o(present));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task start(input logic [3:0] cfg);
    @(negedge clk);
    rst_n = 1'b0;
    {pce, fce, are, pre} = cfg;
    {shorted, absent} = 2'h0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task wait_sum(input logic [4:0] exp);
    for (i = 0; sum_p !== 1'b1 && i < 300; i++) @(negedge clk);
    chk("summary", 5'h01, {4'h0, sum_p});
    chk("features", exp, feat);
  endtask
  // Steps past the pulse so the next wait sees a fresh one
  task wait_rep(input logic [1:0] exp);
    for (i = 0; st_p !== 1'b1 && i < 300; i++) @(negedge clk);
    chk("report", {2'h0, 1'b1, exp}, {2'h0, st_p, rep});
    @(negedge clk);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Whole run is under 400 cycles; allow 15000 cycles
  initial begin
    #300000;
    err_count++;
    conclude;
  end
  initial begin
    err_count = 0;
    n_checks = 0;
    rst_n = 1'b0;
    {pce, fce, are, pre, shorted, absent} = 6'h00;
    start(4'hD);
    wait_sum(5'h07);
    wait_rep(`ST_INIT);
    wait_rep(`ST_OK);
    chk("state", {3'h0, `ST_OK}, {3'h0, st});
    shorted = 1'b1;
    wait_rep(`ST_SHORT);
    chk("power_off", 5'h00, {4'h0, poff});
    chk("power_status", 5'h01, {4'h0, pwr_on});
    shorted = 1'b0;
    seen = 0;
    for (i = 0; i < 40; i++) begin
      @(negedge clk);
      if (st_p === 1'b1) seen++;
    end
    chk("reports", 5'h00, seen[4:0]);
    chk("state", {3'h0, `ST_SHORT}, {3'h0, st});
    fce = 1'b0;
    repeat (10) @(negedge clk);
    fce = 1'b1;
    repeat (10) @(negedge clk);
    chk("state", {3'h0, `ST_OK}, {3'h0, st});
    absent = 1'b1;
    wait_rep(`ST_OPEN);
    absent = 1'b0;
    wait_rep(`ST_OK);
    $display("test latched short done");
    start(4'hE);
    wait_sum(5'h1B);
    wait_rep(`ST_INIT);
    wait_rep(`ST_OK);
    shorted = 1'b1;
    wait_rep(`ST_SHORT);
    repeat (3) @(negedge clk);
    chk("power_off", 5'h01, {4'h0, poff});
    chk("power_status", 5'h00, {4'h0, pwr_on});
    repeat (60) @(negedge clk);
    shorted = 1'b0;
    wait_rep(`ST_OK);
    chk("power_off", 5'h00, {4'h0, poff});
    chk("power_status", 5'h01, {4'h0, pwr_on});
    $display("test auto retry done");
    start(4'h7);
    seen = 0;
    for (i = 0; i < 80; i++) begin
      @(negedge clk);
      shorted = (i > 40);
      if (st_p === 1'b1 || sum_p === 1'b1) seen++;
    end
    chk("reports", 5'h00, seen[4:0]);
    chk("power_off", 5'h00, {4'h0, poff});
    $display("test control off done");
    conclude;
  end
endmodule
`default_nettype wire
